// ### core/crm_clock_reset_manager.sv
// clock and reset manager with pin status registers
// assumes mclk is the serial link clock; derived clocks leave as enables
`timescale 1ns/10ps
`default_nettype none
module crm_clock_reset_manager (
    input wire logic mclk, // serial link clock
    input wire logic reset, // primary asynchronous reset
    input wire logic hard_reset_n_in, // hard reset pin
    input wire logic power_on_reset_n_in, // power-on reset pin
    output logic power_on_reset_n_out, // internal power-on reset
    input wire logic soft_reset_req, // software reset from instruction port
    input wire logic [crm_pkg::CRM_CFG_W-1:0] clock_strap_in, // clock straps
    input wire logic [crm_pkg::CRM_ADDR_W-1:0] chip_address_in, // address pins
    input wire logic adc_clock_in, // external adc clock pin
    input wire logic crossing_clock_in, // external crossing clock pin
    input wire logic neighbor_flow_stop_in, // incoming flow stop
    input wire logic daisy_chain_in, // daisy chain input
    input wire logic heartbeat_trigger, // heartbeat trigger pin
    input wire logic event_trigger_in, // event trigger pin
    input wire logic crossing_sync_pulse, // crossing counter sync pin
    input wire logic reg_rd_en, // register read strobe
    input wire logic [crm_pkg::CRM_REG_AW-1:0] reg_addr, // register offset
    output logic [crm_pkg::CRM_REG_DW-1:0] reg_rdata, // read data
    output logic serial_full_clock, // full rate serializer enable
    output logic serial_half_clock, // half rate enable
    output logic sar_converter_clock, // sar converter enable
    output logic crossing_clock, // crossing enable
    output logic adc_sample_clock, // adc sample enable
    output logic [crm_pkg::CRM_ADDR_W-1:0] chip_address, // synced address
    output logic config_reset, // reset for config registers
    output logic serial_reset, // link clock logic reset
    output logic half_reset, // half rate logic reset
    output logic adc_reset, // adc domain reset
    output logic crossing_reset // crossing domain reset
);
    import crm_pkg::*;

    crm_rst_if #(.N(CRM_NDOM)) rif ();

    logic por_ff, soft_ff;
    logic [CRM_CFG_W-1:0] strap_m_ff, strap_s_ff, cfg_ff;
    logic [CRM_ADDR_W-1:0] addr_m_ff, addr_s_ff;
    logic [CRM_PIN_W-1:0] pin_m_ff, pin_s_ff;
    logic [2:0] adc_sh_ff, bx_sh_ff;
    logic [CRM_DIV_W-1:0] div_cnt_ff;
    logic [CRM_BXDIV_W-1:0] bxdiv_ff;
    logic half_ff, sar_ff, bx_ff, adc_ff;
    logic [CRM_REG_DW-1:0] rdata_ff;

    function automatic logic [CRM_DIV_W-1:0] crm_mask(input logic [2:0] k);
        crm_mask = 7'h7F >> (3'h7 - k);
    endfunction : crm_mask

    // resets
    wire hard_arst = reset | ~hard_reset_n_in | ~power_on_reset_n_in;
    wire tree_rst = reset | config_reset;
    wire dom_arst = config_reset | soft_ff;

    assign rif.arst[CRM_DOM_CFG] = hard_arst;
    assign rif.arst[CRM_DOM_SERIAL] = hard_arst | soft_ff;
    assign rif.arst[CRM_DOM_HALF] = dom_arst;
    // the adc domain starts only after the link domain, so release is 2+2
    assign rif.arst[CRM_DOM_ADC] = serial_reset;
    assign rif.arst[CRM_DOM_BX] = dom_arst;
    assign rif.step[CRM_DOM_CFG] = 1'b1;
    assign rif.step[CRM_DOM_SERIAL] = 1'b1;
    assign rif.step[CRM_DOM_HALF] = half_ff;
    assign rif.step[CRM_DOM_ADC] = adc_ff;
    assign rif.step[CRM_DOM_BX] = bx_ff;

    crm_reset_sync #(.N(CRM_NDOM)) u_sync (
        .mclk(mclk),
        .rif(rif)
    );

    assign config_reset = rif.sync_rst[CRM_DOM_CFG];
    assign serial_reset = rif.sync_rst[CRM_DOM_SERIAL];
    assign half_reset = rif.sync_rst[CRM_DOM_HALF];
    assign adc_reset = rif.sync_rst[CRM_DOM_ADC];
    assign crossing_reset = rif.sync_rst[CRM_DOM_BX];

    // software reset is an instruction-port level on mclk; registering it
    // keeps decode glitches off the asynchronous clears
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            por_ff <= 1'b0;
            soft_ff <= 1'b0;
        end else begin
            por_ff <= 1'b1;
            soft_ff <= soft_reset_req;
        end
    end
    assign power_on_reset_n_out = por_ff;

    // straps keep shifting during reset, so the copy taken as config_reset
    // releases is the pin value and not a cleared synchroniser; limitation:
    // the primary reset must stand for at least two link cycles
    always_ff @(posedge mclk) begin
        strap_m_ff <= clock_strap_in;
        strap_s_ff <= strap_m_ff;
    end

    // pin synchronisers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            addr_m_ff <= CRM_RST_CHIP_ADDR;
            addr_s_ff <= CRM_RST_CHIP_ADDR;
            pin_m_ff <= CRM_RST_PIN_STATUS;
            pin_s_ff <= CRM_RST_PIN_STATUS;
        end else begin
            addr_m_ff <= chip_address_in;
            addr_s_ff <= addr_m_ff;
            pin_m_ff <= {crossing_sync_pulse, event_trigger_in,
                heartbeat_trigger, daisy_chain_in, neighbor_flow_stop_in};
            pin_s_ff <= pin_m_ff;
        end
    end
    assign chip_address = addr_s_ff;

    // straps are only taken while config_reset holds, so a soft reset or a
    // strap wiggle in operation never retunes a running divider
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cfg_ff <= CRM_RST_CLK_STRAP;
        end else if (config_reset) begin
            cfg_ff <= strap_s_ff;
        end
    end

    // strap decode
    wire [2:0] key = {cfg_ff[CRM_CFG_RATE_HI], cfg_ff[1:0]};
    wire [2:0] sar_log = crm_sar_log(key);
    wire [2:0] bx_log = crm_bx_log(key);
    // adc = sar / 8 is kept by construction; the straps must not ask more
    wire [2:0] adc_log = 3'(sar_log + CRM_SAR_PER_ADC_LOG);
    wire [2:0] adc_bx_log = 3'(adc_log - bx_log);
    wire gate = cfg_ff[CRM_CFG_GATE];
    crm_adc_src_t adc_src;
    assign adc_src = cfg_ff[CRM_CFG_ADC_EXT] ? CRM_SRC_EXTERNAL :
        cfg_ff[CRM_CFG_ADC_BX] ? CRM_SRC_CROSSING : CRM_SRC_SERIAL;

    // external clocks: two stages, then an edge stage
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            adc_sh_ff <= 3'h0;
            bx_sh_ff <= 3'h0;
        end else begin
            adc_sh_ff <= {adc_sh_ff[1:0], adc_clock_in};
            bx_sh_ff <= {bx_sh_ff[1:0], crossing_clock_in};
        end
    end
    wire adc_ext_edge = adc_sh_ff[1] & ~adc_sh_ff[2];
    wire bx_ext_edge = bx_sh_ff[1] & ~bx_sh_ff[2];

    // clock tree
    wire [CRM_DIV_W-1:0] sar_m = crm_mask(sar_log);
    wire [CRM_DIV_W-1:0] adc_m = crm_mask(adc_log);
    wire [CRM_DIV_W-1:0] bx_m = crm_mask(bx_log);
    wire [CRM_DIV_W-1:0] abx_m = crm_mask(adc_bx_log);
    wire [CRM_DIV_W-1:0] bxdiv_w = {4'h0, bxdiv_ff};
    wire nxt_sar = (div_cnt_ff & sar_m) == sar_m;
    wire bx_int = (div_cnt_ff & bx_m) == bx_m;
    // a slower external crossing clock slows bxdiv_ff and the crossing enable; div_cnt_ff still counts every cycle
    wire bx_raw = cfg_ff[CRM_CFG_BX_EXT] ? bx_ext_edge : bx_int;
    wire adc_int = (div_cnt_ff & adc_m) == adc_m;
    wire adc_bx = bx_raw && ((bxdiv_w & abx_m) == abx_m);
    logic nxt_adc;
    always_comb begin
        unique case (adc_src)
            CRM_SRC_SERIAL: nxt_adc = adc_int;
            CRM_SRC_CROSSING: nxt_adc = adc_bx;
            default: nxt_adc = adc_ext_edge;
        endcase
    end
    wire nxt_half = div_cnt_ff[0] & ~gate;
    wire nxt_bx = bx_raw & ~gate;

    always_ff @(posedge mclk or posedge tree_rst) begin
        if (tree_rst) begin
            div_cnt_ff <= '0;
            bxdiv_ff <= '0;
            half_ff <= 1'b0;
            sar_ff <= 1'b0;
            bx_ff <= 1'b0;
            adc_ff <= 1'b0;
        end else begin
            div_cnt_ff <= div_cnt_ff + 7'h01;
            if (bx_raw) begin
                bxdiv_ff <= bxdiv_ff + 3'h1;
            end
            half_ff <= nxt_half;
            sar_ff <= nxt_sar;
            bx_ff <= nxt_bx;
            adc_ff <= nxt_adc;
        end
    end
    assign serial_full_clock = ~tree_rst;
    assign serial_half_clock = half_ff;
    assign sar_converter_clock = sar_ff;
    assign crossing_clock = bx_ff;
    assign adc_sample_clock = adc_ff;

    // register read port, one cycle latency, unmapped offsets read zero
    wire hit_addr = reg_addr == CRM_OFS_CHIP_ADDR;
    wire hit_strap = reg_addr == CRM_OFS_CLK_STRAP;
    wire hit_pin = reg_addr == CRM_OFS_PIN_STATUS;
    wire [CRM_REG_DW-1:0] rd_mux = hit_addr ? {4'h0, addr_s_ff} :
        hit_strap ? {1'b0, strap_s_ff} :
        hit_pin ? {3'h0, pin_s_ff} : CRM_RDATA_NONE;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata_ff <= CRM_RDATA_NONE;
        end else if (reg_rd_en) begin
            rdata_ff <= rd_mux;
        end
    end
    assign reg_rdata = rdata_ff;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // clock tree checks pause while a hard reset holds the tree cleared
    chk_half_rate_alt: assert property (disable iff (tree_rst)
        !tree_rst && !gate && serial_half_clock |=> !serial_half_clock
            ##1 serial_half_clock)
        else $error("half clock enable does not alternate");
    chk_full_rate_on: assert property (
        !tree_rst |-> serial_full_clock)
        else $error("full clock enable dropped");
    chk_gate_off_clk: assert property (disable iff (tree_rst)
        gate && !tree_rst |=> !serial_half_clock && !crossing_clock)
        else $error("gated clock still running");
    chk_bx_320_period: assert property (disable iff (tree_rst)
        !tree_rst && !gate && !cfg_ff[CRM_CFG_BX_EXT] && key == 3'h3
            && crossing_clock |=> !crossing_clock [*7] ##1 crossing_clock)
        else $error("crossing enable not one in eight at 320");
    chk_strap_decode: assert property (
        cfg_ff == 7'h03 |-> sar_log == 3'h1 && bx_log == 3'h3
            && adc_src == CRM_SRC_SERIAL)
        else $error("strap 0000011 decoded wrongly");
    chk_adc_ext_follow: assert property (disable iff (tree_rst)
        !tree_rst && adc_src == CRM_SRC_EXTERNAL && adc_ext_edge
            |=> adc_sample_clock)
        else $error("external adc edge not forwarded");
    chk_strap_reg_rd: assert property (
        reg_rd_en && reg_addr == CRM_OFS_CLK_STRAP
            |=> reg_rdata == {1'b0, $past(strap_s_ff)})
        else $error("strap status read wrong");
    chk_addr_reg_rd: assert property (
        reg_rd_en && reg_addr == CRM_OFS_CHIP_ADDR
            |=> reg_rdata == {4'h0, $past(addr_s_ff)})
        else $error("chip address read wrong");
    chk_pin_reg_rd: assert property (
        reg_rd_en && reg_addr == CRM_OFS_PIN_STATUS
            |=> reg_rdata == {3'h0, $past(pin_s_ff)})
        else $error("pin status read wrong");
    chk_soft_keeps_cfg: assert property (
        !config_reset |=> $stable(cfg_ff))
        else $error("straps retaken outside hard reset");
    chk_hard_release: assert property (
        $fell(config_reset) && !soft_ff |-> ##[0:2] !serial_reset)
        else $error("link domain slow to leave reset");
    chk_adc_release: assert property (
        $fell(serial_reset) && adc_src == CRM_SRC_SERIAL
            |-> ##[1:300] !adc_reset)
        else $error("adc domain slow to leave reset");

    cov_gated_mode: cover property (gate && adc_sample_clock);
    cov_bx_derived: cover property (
        adc_src == CRM_SRC_CROSSING && adc_sample_clock);
    cov_soft_reset: cover property ($rose(soft_ff) ##[1:20] $fell(serial_reset));
    cov_adc_external: cover property (
        adc_src == CRM_SRC_EXTERNAL && adc_sample_clock);
endmodule : crm_clock_reset_manager
`default_nettype wire

// ### core/crm_pkg.sv
// constants, field layout and strap decode of the clock and reset manager
// assumes mclk is the serial link clock and that all ticks are mclk enables
package crm_pkg;
    localparam int CRM_CFG_W = 7;
    localparam int CRM_ADDR_W = 4;
    localparam int CRM_PIN_W = 5;
    localparam int CRM_REG_AW = 8;
    localparam int CRM_REG_DW = 8;
    localparam int CRM_DIV_W = 7;
    localparam int CRM_BXDIV_W = 3;
    localparam int CRM_SYNC_STAGES = 2;

    // register map, read only
    localparam logic [7:0] CRM_OFS_CHIP_ADDR = 8'h00;
    localparam logic [7:0] CRM_OFS_CLK_STRAP = 8'h22;
    localparam logic [7:0] CRM_OFS_PIN_STATUS = 8'h23;
    localparam logic [3:0] CRM_RST_CHIP_ADDR = 4'h0;
    localparam logic [6:0] CRM_RST_CLK_STRAP = 7'h00;
    localparam logic [4:0] CRM_RST_PIN_STATUS = 5'h00;
    localparam logic [7:0] CRM_RDATA_NONE = 8'h00;

    // strap fields
    localparam int CRM_CFG_BX_EXT = 2;
    localparam int CRM_CFG_ADC_BX = 3;
    localparam int CRM_CFG_RATE_HI = 4;
    localparam int CRM_CFG_ADC_EXT = 5;
    localparam int CRM_CFG_GATE = 6;

    // input pin status fields
    localparam int CRM_PIN_FLOW = 0;
    localparam int CRM_PIN_DAISY = 1;
    localparam int CRM_PIN_HBEAT = 2;
    localparam int CRM_PIN_TRIG = 3;
    localparam int CRM_PIN_SYNC = 4;

    // the sar clock runs at eight times the adc clock
    localparam logic [2:0] CRM_SAR_PER_ADC_LOG = 3'h3;

    // reset domains
    localparam int CRM_DOM_CFG = 0;
    localparam int CRM_DOM_SERIAL = 1;
    localparam int CRM_DOM_HALF = 2;
    localparam int CRM_DOM_ADC = 3;
    localparam int CRM_DOM_BX = 4;
    localparam int CRM_NDOM = 5;

    typedef enum logic [1:0] {
        CRM_SRC_SERIAL,
        CRM_SRC_CROSSING,
        CRM_SRC_EXTERNAL
    } crm_adc_src_t;

    // key is {rate_hi, cfg[1:0]}; result is log2 of serial-to-sar divide
    function automatic logic [2:0] crm_sar_log(input logic [2:0] key);
        unique case (key)
            3'h3: crm_sar_log = 3'h1;
            3'h7: crm_sar_log = 3'h2;
            3'h5: crm_sar_log = 3'h3;
            3'h2: crm_sar_log = 3'h0;
            3'h6: crm_sar_log = 3'h1;
            3'h1: crm_sar_log = 3'h2;
            3'h4: crm_sar_log = 3'h0;
            3'h0: crm_sar_log = 3'h1;
        endcase
    endfunction : crm_sar_log

    // log2 of serial-to-crossing divide for 320, 160 and 80 MHz links
    function automatic logic [2:0] crm_bx_log(input logic [2:0] key);
        unique case (key)
            3'h3, 3'h7, 3'h5: crm_bx_log = 3'h3;
            3'h2, 3'h6, 3'h1: crm_bx_log = 3'h2;
            3'h4, 3'h0: crm_bx_log = 3'h1;
        endcase
    endfunction : crm_bx_log
endpackage : crm_pkg

// ### core/crm_rst_if.sv
// reset request and synchronised reset bundle between manager and synchroniser
// assumes every domain steps on an mclk enable
`timescale 1ns/10ps
`default_nettype none
interface crm_rst_if #(parameter int N = 5);
    logic [N-1:0] arst;
    logic [N-1:0] step;
    logic [N-1:0] sync_rst;
    modport sync (input arst, input step, output sync_rst);
    modport user (output arst, output step, input sync_rst);
endinterface : crm_rst_if
`default_nettype wire

// ### core/crm_reset_sync.sv
// per-domain reset synchroniser: asynchronous assert, release after two steps
// assumes arst is glitch free and step is a one-cycle domain enable
`timescale 1ns/10ps
`default_nettype none
module crm_reset_sync #(
    parameter int N = 5
) (
    input wire logic mclk, // serial link clock
    crm_rst_if.sync rif // requests in, synchronised resets out
);
    import crm_pkg::*;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_dom
            logic [CRM_SYNC_STAGES-1:0] sh_ff;
            always_ff @(posedge mclk or posedge rif.arst[gi]) begin
                if (rif.arst[gi]) begin
                    sh_ff <= '1;
                end else if (rif.step[gi]) begin
                    sh_ff <= {sh_ff[CRM_SYNC_STAGES-2:0], 1'b0};
                end
            end
            assign rif.sync_rst[gi] = sh_ff[CRM_SYNC_STAGES-1];
        end
    endgenerate
endmodule : crm_reset_sync
`default_nettype wire

// ### tb/crm_far_side.sv
// far side model: external clock sources and reset circuitry
// assumes the bench calls pulse_pin from code aligned to mclk
`timescale 1ns/10ps
`default_nettype none
module crm_far_side (
    input wire logic mclk, // link clock
    output logic adc_clock_in, // external adc clock
    output logic crossing_clock_in, // external crossing clock
    output logic hard_reset_n_in, // hard reset pin
    output logic power_on_reset_n_in // power-on reset pin
);
    // odd offsets keep both sources out of phase with mclk
    initial begin
        crossing_clock_in = 1'b0;
        #7;
        forever #200 crossing_clock_in = ~crossing_clock_in;
    end
    // period 16x that of the sar clock of the 20 MHz adc settings it is used with
    initial begin
        adc_clock_in = 1'b0;
        #11;
        forever #400 adc_clock_in = ~adc_clock_in;
    end
    initial begin
        hard_reset_n_in = 1'b1;
        power_on_reset_n_in = 1'b1;
    end
    // held low three link cycles, beyond the one cycle minimum
    task automatic pulse_pin(input logic por);
        @(posedge mclk);
        #2;
        if (por) begin
            power_on_reset_n_in = 1'b0;
        end else begin
            hard_reset_n_in = 1'b0;
        end
        repeat (3) @(posedge mclk);
        #2;
        power_on_reset_n_in = 1'b1;
        hard_reset_n_in = 1'b1;
    endtask : pulse_pin
endmodule : crm_far_side
`default_nettype wire

// ### tb/crm_clock_reset_manager_tb.sv
// self-checking bench for the clock and reset manager
// assumes crm_far_side supplies the external clocks and reset pins
`timescale 1ns/10ps
`default_nettype none
module crm_clock_reset_manager_tb;
    import crm_pkg::*;
    logic mclk, reset, hard_reset_n_in, power_on_reset_n_in;
    logic power_on_reset_n_out, soft_reset_req, reg_rd_en;
    logic adc_clock_in, crossing_clock_in, neighbor_flow_stop_in;
    logic daisy_chain_in, heartbeat_trigger, event_trigger_in;
    logic crossing_sync_pulse, serial_full_clock, serial_half_clock;
    logic sar_converter_clock, crossing_clock, adc_sample_clock;
    logic config_reset, serial_reset, half_reset, adc_reset;
    logic crossing_reset;
    logic [6:0] clock_strap_in;
    logic [3:0] chip_address_in, chip_address;
    logic [7:0] reg_addr, reg_rdata, n_half, n_sar, n_bx, n_adc;
    int errors = 0;
    int checks_done = 0;
    int n;
    // tick counts expected in a 128 cycle window, adc always sar/8 or less
    localparam logic [6:0] CFG [12] = '{7'h03, 7'h13, 7'h11, 7'h02, 7'h10,
        7'h00, 7'h12, 7'h01, 7'h07, 7'h0F, 7'h23, 7'h27};
    localparam logic [7:0] SAR_N [12] = '{64, 32, 16, 128, 128, 64, 64, 32,
        64, 64, 64, 64};
    localparam logic [7:0] BX_N [12] = '{16, 16, 16, 32, 64, 64, 32, 32,
        8, 8, 16, 8};
    localparam logic [7:0] ADC_N [12] = '{8, 4, 2, 16, 16, 8, 8, 4,
        8, 4, 4, 4};

    crm_clock_reset_manager crm_clock_reset_manager_inst (
        .mclk, .reset, .hard_reset_n_in, .power_on_reset_n_in,
        .power_on_reset_n_out, .soft_reset_req, .clock_strap_in,
        .chip_address_in, .adc_clock_in, .crossing_clock_in,
        .neighbor_flow_stop_in, .daisy_chain_in, .heartbeat_trigger,
        .event_trigger_in, .crossing_sync_pulse, .reg_rd_en, .reg_addr,
        .reg_rdata, .serial_full_clock, .serial_half_clock,
        .sar_converter_clock, .crossing_clock, .adc_sample_clock,
        .chip_address, .config_reset, .serial_reset, .half_reset,
        .adc_reset, .crossing_reset
    );
    crm_far_side crm_far_side_inst (
        .mclk, .adc_clock_in, .crossing_clock_in, .hard_reset_n_in,
        .power_on_reset_n_in
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        give_verdict();
    end

    task automatic compare(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t seen %0h expected %0h",
                $time, seen, exp);
        end
    endtask : compare

    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #2;
    endtask : step

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        step(1);
        reg_rd_en = 1'b1;
        reg_addr = a;
        step(1);
        reg_rd_en = 1'b0;
        compare(reg_rdata, e);
    endtask : rd

    // straps settle through the synchroniser before the pin goes low
    task automatic set_cfg(input logic [6:0] c);
        step(1);
        clock_strap_in = c;
        step(3);
        crm_far_side_inst.pulse_pin(1'b0);
        step(200);
    endtask : set_cfg

    task automatic count_ticks();
        n_half = 8'h00;
        n_sar = 8'h00;
        n_bx = 8'h00;
        n_adc = 8'h00;
        repeat (128) begin
            step(1);
            n_half += {7'h00, serial_half_clock};
            n_sar += {7'h00, sar_converter_clock};
            n_bx += {7'h00, crossing_clock};
            n_adc += {7'h00, adc_sample_clock};
        end
    endtask : count_ticks

    task automatic rates(input int k);
        count_ticks();
        compare(n_half, 8'h40);
        compare(n_sar, SAR_N[k]);
        compare(n_bx, BX_N[k]);
        compare(n_adc, ADC_N[k]);
        compare({7'h00, serial_full_clock}, 8'h01);
    endtask : rates

    initial begin
        reset = 1'b1;
        soft_reset_req = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        clock_strap_in = 7'h03;
        chip_address_in = 4'h0;
        {crossing_sync_pulse, event_trigger_in, heartbeat_trigger,
            daisy_chain_in, neighbor_flow_stop_in} = 5'h00;
        step(2);
        reset = 1'b0;
        step(3);
        compare({7'h00, power_on_reset_n_out}, 8'h01);
        rates(0);
        for (int k = 0; k < 12; k++) begin
            set_cfg(CFG[k]);
            rd(CRM_OFS_CLK_STRAP, {1'b0, CFG[k]});
            rates(k);
        end
        $display("test strap decode done");
        set_cfg(7'h43);
        count_ticks();
        compare(n_half, 8'h00);
        compare(n_bx, 8'h00);
        compare({6'h00, half_reset, crossing_reset}, 8'h03);
        $display("test gated mode done");
        set_cfg(7'h03);
        clock_strap_in = 7'h11;
        step(3);
        rd(CRM_OFS_CLK_STRAP, 8'h11);
        rates(0);
        soft_reset_req = 1'b1;
        step(4);
        compare({3'h0, config_reset, serial_reset, half_reset, adc_reset,
            crossing_reset}, 8'h0F);
        soft_reset_req = 1'b0;
        step(200);
        rates(0);
        $display("test soft reset done");
        for (int p = 0; p < 2; p++) begin
            fork
                crm_far_side_inst.pulse_pin(p[0]);
                begin
                    @(negedge hard_reset_n_in or negedge power_on_reset_n_in);
                    #1;
                    compare({6'h00, config_reset, serial_reset},
                        8'h03);
                end
            join
            n = 0;
            while (config_reset === 1'b1 && n < 10) begin
                step(1);
                n++;
            end
            compare(8'(n <= 2), 8'h01);
            while (adc_reset === 1'b1 && n < 300) begin
                step(1);
                n++;
            end
            compare(8'(n <= 132), 8'h01);
            step(100);
            rates(2);
        end
        $display("test hard and power-on reset done");
        for (int v = 0; v < 2; v++) begin
            {crossing_sync_pulse, event_trigger_in, heartbeat_trigger,
                daisy_chain_in, neighbor_flow_stop_in} = v ? 5'h0A : 5'h15;
            chip_address_in = v ? 4'h5 : 4'hA;
            step(4);
            rd(CRM_OFS_CHIP_ADDR, {4'h0, chip_address_in});
            rd(CRM_OFS_PIN_STATUS, v ? 8'h0A : 8'h15);
            compare({4'h0, chip_address}, {4'h0, chip_address_in});
        end
        rd(8'h01, CRM_RDATA_NONE);
        rd(8'h24, CRM_RDATA_NONE);
        $display("test pin status done");
        give_verdict();
    end
endmodule : crm_clock_reset_manager_tb
`default_nettype wire
